/* design/audio_pwm_control_status_regs.sv */
`timescale 1ns/1ps
`include "audio_regs_map.svh"

module audio_pwm_control_status_regs #(
    parameter logic [5:0] PART_ID = 6'h2A  // Arbitrary identification value.
) (
    // Clock and reset.
    input  wire logic                       clk_sys,
    input  wire logic                       srst,
    // Register access from the serial-control engine.
    input  wire audio_regs_pkg::reg_req_t   req,
    output logic [7:0]                      rd_data,
    output logic                            rd_valid,
    // Hardware status inputs.
    input  wire audio_regs_pkg::hw_status_t hw,
    // Decoded clock configuration.
    output logic [17:0]                     sample_rate_hz,
    output logic [9:0]                      mclk_ratio,
    output logic                            clock_config_valid,
    // Tone, AM and general configuration.
    output logic [31:0]                     master_gain,
    output logic [31:0]                     bass_set_select,
    output logic [31:0]                     bass_level,
    output logic [31:0]                     treble_set_select,
    output logic [31:0]                     treble_level,
    output logic                            am_enable,
    output logic [1:0]                      am_sequence,
    output logic                            am_if_select,
    output logic                            am_use_binary_tuning,
    output logic [31:0]                     supply_comp_range,
    output logic                            six_channel_mode,
    output logic                            supply_volume_compensation_en
);

    audio_regs_pkg::state_t state;
    audio_regs_pkg::state_t next_state;

    logic                   ratio_ok;
    logic                   in_words;
    logic [2:0]             word_idx;
    logic [1:0]             lane;
    logic [7:0]             word_offset;

    // Address helpers for the four-byte words; byte 0 is the most significant.
    assign word_offset = req.subaddr - `WORD_FIRST;
    assign in_words    = (req.subaddr >= `WORD_FIRST) && (req.subaddr <= `WORD_LAST);
    assign word_idx    = word_offset[2:0];
    assign lane        = 2'h3 - req.byte_idx;

    // The ratio code 111 is reserved and makes the configuration invalid.
    assign ratio_ok           = (state.clk_ratio != `CLK_RATIO_RESERVED);
    assign clock_config_valid = ratio_ok && hw.clock_ok;

    // Sample rate decode from the stored rate code.
    always_comb
    begin
        case (state.clk_rate)
            3'h0:    sample_rate_hz = 18'd32000;
            3'h1:    sample_rate_hz = 18'd38000;
            3'h2:    sample_rate_hz = 18'd44100;
            3'h3:    sample_rate_hz = 18'd48000;
            3'h4:    sample_rate_hz = 18'd88200;
            3'h5:    sample_rate_hz = 18'd96000;
            3'h6:    sample_rate_hz = 18'd176400;
            default: sample_rate_hz = 18'd192000;
        endcase
    end

    // Master clock ratio decode; the reserved code yields zero.
    always_comb
    begin
        case (state.clk_ratio)
            3'h0:    mclk_ratio = 10'd64;
            3'h1:    mclk_ratio = 10'd128;
            3'h2:    mclk_ratio = 10'd192;
            3'h3:    mclk_ratio = 10'd256;
            3'h4:    mclk_ratio = 10'd384;
            3'h5:    mclk_ratio = 10'd512;
            3'h6:    mclk_ratio = 10'd768;
            default: mclk_ratio = 10'd0;
        endcase
    end

    // Next-state logic: writes, sticky flags and read data.
    always_comb
    begin
        next_state          = state;
        next_state.rd_valid = 1'b0;

        // Writes. Reserved sub-addresses and the append port leave all state alone.
        if (req.wr)
        begin
            if (req.subaddr == `SUB_SAMPLE_CLOCK_CONFIG)
            begin
                // Bit D1 is dropped and D0 is not writable.
                next_state.clk_rate  = req.wdata[`CLK_RATE_MSB:`CLK_RATE_LSB];
                next_state.clk_ratio = req.wdata[`CLK_RATIO_MSB:`CLK_RATIO_LSB];
            end
            else if (req.subaddr == `SUB_FAULT_FLAGS)
            begin
                // Writing a zero clears a flag; writing a one keeps it as it is.
                next_state.faults = state.faults & req.wdata[`FAULT_MSB:`FAULT_LSB];
            end
            else if (in_words)
            begin
                next_state.words[word_idx][lane*8 +: 8] = req.wdata;
            end
        end

        // Reads return one byte, registered, with a one-cycle valid.
        if (req.rd)
        begin
            next_state.rd_valid = 1'b1;
            next_state.rd_data  = 8'h00;
            if (req.subaddr == `SUB_SAMPLE_CLOCK_CONFIG)
            begin
                next_state.rd_data = {state.clk_rate, state.clk_ratio, 1'b0, clock_config_valid};
            end
            else if (req.subaddr == `SUB_DEVICE_STATUS)
            begin
                next_state.rd_data = {state.clip_seen, hw.bank_busy, PART_ID};
                next_state.clip_seen = 1'b0;
            end
            else if (req.subaddr == `SUB_FAULT_FLAGS)
            begin
                next_state.rd_data = {state.faults, 3'h0};
            end
            else if (in_words)
            begin
                next_state.rd_data = state.words[word_idx][lane*8 +: 8];
            end
        end

        // Hardware events win over a clear in the same cycle.
        if (hw.clip_event)
        begin
            next_state.clip_seen = 1'b1;
        end
        next_state.faults = next_state.faults | hw.fault_event;

        // Synchronous reset to documented defaults.
        if (srst)
        begin
            next_state.clk_rate  = `CLK_RATE_RESET;
            next_state.clk_ratio = `CLK_RATIO_RESET;
            next_state.clip_seen = 1'b0;
            next_state.faults    = 5'h00;
            next_state.rd_data   = 8'h00;
            next_state.rd_valid  = 1'b0;
            next_state.words[0]  = `RST_MASTER_GAIN;
            next_state.words[1]  = `RST_BASS_SET_SELECT;
            next_state.words[2]  = `RST_BASS_LEVEL;
            next_state.words[3]  = `RST_TREBLE_SET_SELECT;
            next_state.words[4]  = `RST_TREBLE_LEVEL;
            next_state.words[5]  = `RST_AM_SETUP;
            next_state.words[6]  = `RST_SUPPLY_COMP_RANGE;
            next_state.words[7]  = `RST_GLOBAL_CONFIG;
        end
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
    end

    // Outputs straight from the stored state.
    assign rd_data                       = state.rd_data;
    assign rd_valid                      = state.rd_valid;
    assign master_gain                   = state.words[0];
    assign bass_set_select               = state.words[1];
    assign bass_level                    = state.words[2];
    assign treble_set_select             = state.words[3];
    assign treble_level                  = state.words[4];
    assign am_enable                     = state.words[5][`AM_ENABLE_BIT];
    assign am_sequence                   = state.words[5][`AM_SEQ_MSB:`AM_SEQ_LSB];
    assign am_if_select                  = state.words[5][`AM_IF_SEL_BIT];
    assign am_use_binary_tuning          = state.words[5][`AM_USE_BINARY_BIT];
    assign supply_comp_range             = state.words[6];
    assign six_channel_mode              = state.words[7][`GCFG_SIX_CHANNEL_BIT];
    assign supply_volume_compensation_en = state.words[7][`GCFG_COMP_ENABLE_BIT];

endmodule

/* design/audio_regs_map.svh */
`ifndef AUDIO_REGS_MAP_SVH
`define AUDIO_REGS_MAP_SVH

// Sub-addresses of the single-byte registers.
`define SUB_SAMPLE_CLOCK_CONFIG  8'h00
`define SUB_DEVICE_STATUS        8'h01
`define SUB_FAULT_FLAGS          8'h02

// Sub-addresses of the four-byte words and of the append port.
`define SUB_MASTER_GAIN          8'hD9
`define SUB_BASS_SET_SELECT      8'hDA
`define SUB_BASS_LEVEL           8'hDB
`define SUB_TREBLE_SET_SELECT    8'hDC
`define SUB_TREBLE_LEVEL         8'hDD
`define SUB_AM_SETUP             8'hDE
`define SUB_SUPPLY_COMP_RANGE    8'hDF
`define SUB_GLOBAL_CONFIG        8'hE0
`define SUB_BURST_APPEND         8'hFE
`define WORD_FIRST               8'hD9
`define WORD_LAST                8'hE0
`define WORD_COUNT               8

// Clock configuration fields.
`define CLK_RATE_MSB             7
`define CLK_RATE_LSB             5
`define CLK_RATIO_MSB            4
`define CLK_RATIO_LSB            2
`define CLK_VALID_BIT            0
`define CLK_RATIO_RESERVED       3'h7
`define CLK_RATE_RESET           3'h3
`define CLK_RATIO_RESET          3'h3

// Device status fields.
`define STAT_CLIP_BIT            7
`define STAT_BUSY_BIT            6
`define STAT_ID_MSB              5

// Fault flag field: five flags in bits 7 down to 3.
`define FAULT_MSB                7
`define FAULT_LSB                3

// Word reset values, indexed from the first word.
`define RST_MASTER_GAIN          32'h0000_0000
`define RST_BASS_SET_SELECT      32'h0000_0003
`define RST_BASS_LEVEL           32'h0000_0012
`define RST_TREBLE_SET_SELECT    32'h0000_0003
`define RST_TREBLE_LEVEL         32'h0000_0012
`define RST_AM_SETUP             32'h0000_0000
`define RST_SUPPLY_COMP_RANGE    32'h0000_0000
`define RST_GLOBAL_CONFIG        32'h0000_0000

// Field positions inside the words.
`define AM_ENABLE_BIT            20
`define AM_SEQ_MSB               19
`define AM_SEQ_LSB               18
`define AM_IF_SEL_BIT            17
`define AM_USE_BINARY_BIT        16
`define GCFG_SIX_CHANNEL_BIT     1
`define GCFG_COMP_ENABLE_BIT     0

`endif

/* design/audio_regs_pkg.sv */
package audio_regs_pkg;

    // One register access from the serial-control engine.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] subaddr;
        logic [1:0] byte_idx;
        logic [7:0] wdata;
    } reg_req_t;

    // Event and level inputs from the audio path and clock logic.
    typedef struct packed {
        logic       clock_ok;
        logic       clip_event;
        logic       bank_busy;
        logic [4:0] fault_event;
    } hw_status_t;

    // Complete state of the register bank.
    typedef struct packed {
        logic [2:0]        clk_rate;
        logic [2:0]        clk_ratio;
        logic              clip_seen;
        logic [4:0]        faults;
        logic [7:0][31:0]  words;
        logic [7:0]        rd_data;
        logic              rd_valid;
    } state_t;

endpackage

/* sim/audio_regs_props.sv */
`timescale 1ns/1ps
// Checks the clock, status and fault byte reads against clock validity, clip, busy and fault_event[4].
module audio_regs_props #(
    parameter logic [5:0] PART_ID = 6'h2A  // Arbitrary identification value.
) (
    // Clock and reset.
    input wire logic                       clk_sys,
    input wire logic                       srst,
    // Register access and answer.
    input wire audio_regs_pkg::reg_req_t   req,
    input wire logic [7:0]                 rd_data,
    input wire logic                       rd_valid,
    // Status inputs and clock validity.
    input wire audio_regs_pkg::hw_status_t hw,
    input wire logic                       clock_config_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Reads are answered one cycle after the strobe with the addressed byte.
    a_read_answer: assert property (req.rd |=> rd_valid)
        else $error("read strobe got no answer pulse");
    a_id_code: assert property (req.rd && req.subaddr == 8'h01 |=> rd_data[5:0] == PART_ID)
        else $error("identification field wrong");
    a_busy_mirror: assert property (req.rd && req.subaddr == 8'h01 |=> rd_data[6] == $past(hw.bank_busy))
        else $error("busy bit does not follow bank switch");
    a_clip_seen: assert property (req.rd && req.subaddr == 8'h01 && $past(hw.clip_event) |=> rd_data[7])
        else $error("clip bit missing after clip");
    a_fault_sticks: assert property (req.rd && req.subaddr == 8'h02 && $past(hw.fault_event[4]) |=> rd_data[7])
        else $error("phase lock fault not latched");
    a_fault_low: assert property (req.rd && req.subaddr == 8'h02 |=> rd_data[2:0] == 3'h0)
        else $error("unused fault bits not zero");
    a_reserved_zero: assert property (req.rd && req.subaddr >= 8'hE1 |=> rd_data == 8'h00)
        else $error("reserved address read not zero");
    a_clock_low: assert property (req.rd && req.subaddr == 8'h00 |=> rd_data[1:0] == {1'b0, $past(clock_config_valid)})
        else $error("clock byte low bits wrong");
    a_valid_cause: assert property (clock_config_valid |-> hw.clock_ok)
        else $error("clock valid without clock ok");
    // Main scenarios reached.
    c_fault_read: cover property (req.rd && req.subaddr == 8'h02 && hw.fault_event != 5'h00);
    c_busy_read: cover property (req.rd && req.subaddr == 8'h01 && hw.bank_busy);
    c_clock_write: cover property (req.wr && req.subaddr == 8'h00);
endmodule
bind audio_pwm_control_status_regs audio_regs_props #(.PART_ID(PART_ID)) i_audio_regs_props (
    .clk_sys(clk_sys), .srst(srst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .hw(hw),
    .clock_config_valid(clock_config_valid));

/* sim/audio_host_model.sv */
`timescale 1ns/1ps
// Serial-control engine stand-in: one-cycle strobes set up on the falling edge.
module audio_host_model (
    // Clock.
    input  wire logic                clk_sys,
    // Register access.
    output audio_regs_pkg::reg_req_t req,
    input  wire logic [7:0]          rd_data,
    input  wire logic                rd_valid
);
    initial req = '0;
    // Writes one byte; released lines show the inverse of the last value.
    task automatic wr(input logic [7:0] s, input logic [1:0] i, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{1'b1, 1'b0, s, i, d};
        @(negedge clk_sys);
        req = '{1'b0, 1'b0, ~s, ~i, ~d};
    endtask
    // Reads one byte and takes it while the answer pulse stands.
    task automatic rd(input logic [7:0] s, input logic [1:0] i, output logic [7:0] d);
        @(negedge clk_sys);
        req = '{1'b0, 1'b1, s, i, 8'h00};
        @(negedge clk_sys);
        req = '{1'b0, 1'b0, ~s, ~i, 8'hFF};
        d = rd_valid ? rd_data : 'x;
    endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
    localparam logic [5:0] ID = 6'h15;  // Arbitrary identification value.
    // Bench state and design connections.
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    audio_regs_pkg::reg_req_t req;
    audio_regs_pkg::hw_status_t hw = '0;
    logic [7:0] rd_data, q;
    logic rd_valid, clock_config_valid, am_enable, am_if_select, am_use_binary_tuning;
    logic six_channel_mode, supply_volume_compensation_en;
    logic [1:0] am_sequence;
    logic [17:0] sample_rate_hz;
    logic [9:0] mclk_ratio;
    logic [31:0] master_gain, bass_set_select, bass_level, treble_set_select, treble_level, supply_comp_range;
    logic [31:0] x = 32'h8B0A;
    logic [4:0] f;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [17:0] rate_tab [8] = '{18'h07D00, 18'h09470, 18'h0AC44, 18'h0BB80, 18'h15888, 18'h17700, 18'h2B110, 18'h2EE00};
    logic [9:0] ratio_tab [8] = '{10'h040, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300, 10'h000};

    audio_pwm_control_status_regs #(.PART_ID(ID)) i_audio_pwm_control_status_regs (
        .clk_sys, .srst, .req, .rd_data, .rd_valid, .hw, .sample_rate_hz, .mclk_ratio, .clock_config_valid,
        .master_gain, .bass_set_select, .bass_level, .treble_set_select, .treble_level, .am_enable, .am_sequence,
        .am_if_select, .am_use_binary_tuning, .supply_comp_range, .six_channel_mode, .supply_volume_compensation_en);
    audio_host_model i_audio_host_model (.clk_sys, .req, .rd_data, .rd_valid);

    // Clock of 40 ns period.
    always #20 clk_sys = ~clk_sys;
    // Cuts a hung run short.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            give_verdict();
        end
    end

    // Next pseudo-random value.
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected read-back of the clock byte: D1 reads zero, D0 is validity.
    function automatic logic [7:0] clk_byte(input logic [7:0] w, input logic ok);
        return {w[7:2], 1'b0, (w[4:2] != 3'h7) && ok};
    endfunction
    // Reads a byte and compares it.
    task automatic rd_chk(input logic [7:0] s, input logic [1:0] i, input logic [7:0] e);
        i_audio_host_model.rd(s, i, q);
        `CHK(q, e)
    endtask
    // Prints the counts and the verdict.
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        `CHK(bass_set_select, 32'h0000_0003)
        `CHK(bass_level, 32'h0000_0012)
        `CHK(treble_set_select, 32'h0000_0003)
        `CHK(treble_level, 32'h0000_0012)
        `CHK({am_enable, am_sequence, am_if_select, am_use_binary_tuning}, 5'h00)
        `CHK(supply_comp_range, 32'h0000_0000)
        `CHK({six_channel_mode, supply_volume_compensation_en}, 2'h0)
        for (int c = 0; c < 8; c++)
        begin
            x = lfsr(x);
            hw.clock_ok = x[2];
            i_audio_host_model.wr(8'h00, 2'h0, {c[2:0], 3'h7 - c[2:0], x[1:0]});
            `CHK(sample_rate_hz, rate_tab[c])
            `CHK(mclk_ratio, ratio_tab[7 - c])
            `CHK(clock_config_valid, (c != 0) && x[2])
            rd_chk(8'h00, 2'h0, clk_byte({c[2:0], 3'h7 - c[2:0], 2'h0}, x[2]));
        end
        for (int b = 0; b < 4; b++)
            i_audio_host_model.wr(8'hDF, b[1:0], x[31 - 8 * b -: 8]);
        i_audio_host_model.wr(8'hDE, 2'h1, 8'h1F);
        i_audio_host_model.wr(8'hE0, 2'h3, 8'h03);
        i_audio_host_model.wr(8'hE5, 2'h3, 8'hFF);
        i_audio_host_model.wr(8'hFE, 2'h3, 8'hFF);
        `CHK(supply_comp_range, x)
        `CHK({am_enable, am_sequence, am_if_select, am_use_binary_tuning}, 5'h1F)
        `CHK({six_channel_mode, supply_volume_compensation_en}, 2'h3)
        `CHK(master_gain, 32'h0000_0000)
        rd_chk(8'hE5, 2'h3, 8'h00);
        rd_chk(8'hDF, 2'h0, x[31:24]);
        // Sticky faults survive reads and one-writes, zero-writes clear them.
        f = x[8:4] | 5'h10;
        hw.fault_event = f;
        rd_chk(8'h02, 2'h0, {f, 3'h0});
        hw.fault_event = 5'h00;
        rd_chk(8'h02, 2'h0, {f, 3'h0});
        i_audio_host_model.wr(8'h02, 2'h0, 8'hFF);
        rd_chk(8'h02, 2'h0, {f, 3'h0});
        i_audio_host_model.wr(8'h02, 2'h0, 8'h00);
        rd_chk(8'h02, 2'h0, 8'h00);
        // A fault that persists through the zero-write is found set again.
        hw.fault_event = 5'h01;
        i_audio_host_model.wr(8'h02, 2'h0, 8'h00);
        rd_chk(8'h02, 2'h0, 8'h08);
        hw.fault_event = 5'h00;
        // Clip, busy and identification in the status byte.
        hw.clip_event = 1'b1;
        hw.bank_busy = 1'b1;
        rd_chk(8'h01, 2'h0, {2'h3, ID});
        hw.clip_event = 1'b0;
        hw.bank_busy = 1'b0;
        i_audio_host_model.rd(8'h01, 2'h0, q);
        `CHK(q[6:0], {1'b0, ID})
        // A second reset in mid-run brings back every default.
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        `CHK(sample_rate_hz, 18'd48000)
        `CHK(mclk_ratio, 10'd256)
        `CHK(clock_config_valid, hw.clock_ok)
        `CHK(supply_comp_range, 32'h0000_0000)
        `CHK({am_enable, am_sequence, am_if_select, am_use_binary_tuning}, 5'h00)
        `CHK({six_channel_mode, supply_volume_compensation_en}, 2'h0)
        rd_chk(8'h02, 2'h0, 8'h00);
        rd_chk(8'h01, 2'h0, {2'h0, ID});
        give_verdict();
    end
endmodule
